// >>> ssc_baud.sv
// Baud divider giving one pulse per serial clock half period
`default_nettype none
module ssc_baud #(
    parameter int RW = 12
) (
    input  wire logic          i_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_run,
    input  wire logic [RW-1:0] i_ratio_m1,
    output logic               o_half
);
    logic [RW:0] ratio;
    logic [RW:0] half_a;
    logic [RW:0] half_b;
    logic [RW:0] cnt_reg;
    logic        ph_reg;
    logic        half_reg;

    assign ratio  = {1'b0, i_ratio_m1} + {{RW{1'b0}}, 1'b1};
    assign half_a = ratio >> 1;
    assign half_b = ratio - half_a;
    assign o_half = half_reg;

    // ****************************************
    // Divide by 2 to 4096, odd ratios split
    // ****************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg  <= '0;
            ph_reg   <= 1'b0;
            half_reg <= 1'b0;
        end else if (!i_run) begin
            cnt_reg  <= '0;
            ph_reg   <= 1'b0;
            half_reg <= 1'b0;
        end else if (cnt_reg == (ph_reg ? half_b : half_a) - {{RW{1'b0}}, 1'b1}) begin
            cnt_reg  <= '0;
            ph_reg   <= ~ph_reg;
            half_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + {{RW{1'b0}}, 1'b1};
            half_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> ssc_core.sv
// Serial unit with four select lines and an eight entry command loop
// How it works
// R1: Four select lines, zero to three, direction set by mode.
// R2: Single master drives all four select lines.
// R3: Multi master takes line zero as input; lines one to three output or unused.
// R4: Slave samples line zero as select; other lines unused; master drives it.
// R5: Clock delay of 1 to 8 serial cycles after select assert.
// R6: Negation delay of 1 to 8 serial cycles after clock stops.
// R7: Next-access wait of 1 to 8 serial cycles between accesses.
// R8: Each select line polarity chosen by software.
// R9: Up to eight commands run in order, looping back to the first.
// R10: Each command sets select, rate, mode, length, order, burst, delays.
// R11: Writing the transmit buffer starts a master transfer.
// R12: Data output sits at a chosen level while select is negated.
// R13: Receive-full interrupt when received data is stored.
// R14: Transmit-empty interrupt when the buffer accepts new data.
// R15: One error interrupt for mode fault, overrun, underrun, parity.
// R16: Idle interrupt when all activity has ended.
// R17: Event pulses for receive, transmit, error, idle, transfer done.
// R18: Clock held stopped while receive buffer is full.
// R19: Serial clock is peripheral clock divided by 2 to 4096.
// R20: External master clock no faster than peripheral clock over 4.
// R21: Mode fault flag also shows underrun; separate underrun flag.
`default_nettype none
module ssc_core #(
    parameter int NCMD = 8
) (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_enable,
    input  wire logic [1:0]  i_mode,
    input  wire logic [3:0]  i_ssl_pol,
    input  wire logic [2:0]  i_mm_ssl_used,
    input  wire logic        i_mosi_idle,
    input  wire logic        i_par_en,
    input  wire logic [2:0]  i_seq_last,
    input  wire logic        i_cmd_we,
    input  wire logic [2:0]  i_cmd_addr,
    input  wire logic [ssc_pkg::CMD_W-1:0] i_cmd_word,
    input  wire logic        i_tx_wr,
    input  wire logic [31:0] i_tx_data,
    input  wire logic        i_rx_rd,
    input  wire logic        i_err_clr,
    input  wire logic        i_sck,
    input  wire logic        i_mosi,
    input  wire logic        i_miso,
    input  wire logic        i_ssl0,
    output logic [31:0]      o_rx_data,
    output logic             o_modf_flag,
    output logic             o_udr_flag,
    output logic             o_ovr_flag,
    output logic             o_par_flag,
    output logic             o_irq_rx_full,
    output logic             o_irq_tx_empty,
    output logic             o_irq_err,
    output logic             o_irq_idle,
    output logic             o_evt_rx_full,
    output logic             o_evt_tx_empty,
    output logic             o_evt_err,
    output logic             o_evt_idle,
    output logic             o_evt_tx_done,
    output logic             o_sck,
    output logic             o_sck_oe_n,
    output logic             o_mosi,
    output logic             o_mosi_oe_n,
    output logic             o_miso,
    output logic             o_miso_oe_n,
    output logic [3:0]       o_ssl,
    output logic [3:0]       o_ssl_oe_n
);
    import ssc_pkg::*;

    // ****************************************
    // Command table and current fields
    // ****************************************
    logic [CMD_W-1:0] cmd_mem [NCMD];
    logic [2:0]       cmd_ptr_reg;
    logic [CMD_W-1:0] cur;
    logic             is_master;
    logic             is_slave;
    logic             ssl0_act;
    logic             sl_sel;
    logic [4:0]       len;
    logic             cpol;
    logic             cpha;
    logic             lsb;
    logic [2:0]       dly_sel;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < NCMD; i++) begin
                cmd_mem[i] <= CMD_RST;
            end
        end else if (i_cmd_we && (32'(i_cmd_addr) < NCMD)) begin
            cmd_mem[i_cmd_addr] <= i_cmd_word; // R10
        end
    end

    assign is_slave  = i_enable && (i_mode == MODE_SLAVE);
    assign ssl0_act  = (i_ssl0 == i_ssl_pol[0]); // R8
    assign sl_sel    = is_slave && ssl0_act; // R4
    assign cur       = is_slave ? cmd_mem[0] : cmd_mem[cmd_ptr_reg];
    assign len       = cur[F_LEN +: W_LEN];
    assign cpol      = cur[F_CPOL];
    assign cpha      = cur[F_CPHA];
    assign lsb       = cur[F_LSB];

    function automatic logic [31:0] f_rx_ins(input logic [31:0] r, input logic b,
                                             input logic first_lsb, input logic [4:0] n);
        logic [31:0] m;
        m    = 32'h0;
        m[n] = b;
        f_rx_ins = first_lsb ? ((r >> 1) | m) : {r[30:0], b};
    endfunction

    function automatic logic [31:0] f_tx_sh(input logic [31:0] t, input logic first_lsb);
        f_tx_sh = first_lsb ? (t >> 1) : (t << 1);
    endfunction

    // ****************************************
    // Master sequencer
    // ****************************************
    ssc_mst_e   st_reg;
    ssc_mst_e   st_next;
    logic [3:0] dly_cnt_reg;
    logic [5:0] hcnt_reg;
    logic       half;
    logic       dly_done;
    logic       ssl_act_reg;
    logic       ssl_act_next;
    logic       sck_reg;
    logic       tx_full_reg;
    logic       rx_full_reg;
    logic       modf_reg;
    logic       m_start;
    logic       adv;

    assign is_master = i_enable && !modf_reg &&
                       ((i_mode == MODE_SINGLE) || (i_mode == MODE_MULTI));

    ssc_baud #(.RW(W_RATIO)) u_baud (
        .i_clk      (i_clk),
        .i_arst_n   (i_arst_n),
        .i_run      (st_reg != ST_IDLE),
        .i_ratio_m1 (cur[F_RATIO +: W_RATIO]), // R19
        .o_half     (half)
    );

    always_comb begin
        dly_sel = cur[F_CLKD +: W_DLY];
        if (st_reg == ST_NEGD) begin
            dly_sel = cur[F_NEGD +: W_DLY];
        end else if (st_reg == ST_NEXTD) begin
            dly_sel = cur[F_NXTD +: W_DLY];
        end
    end
    assign dly_done = half && (dly_cnt_reg == {dly_sel, 1'b1}); // R5 R6 R7

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE: if (tx_full_reg) begin
                st_next = ST_CLKD; // R11
            end
            ST_CLKD: if (dly_done && !rx_full_reg) begin
                st_next = ST_XFER; // R5 R18
            end
            ST_XFER: if (half && (hcnt_reg == {len, 1'b1})) begin
                st_next = (cur[F_BURST] && tx_full_reg) ? ST_CLKD : ST_NEGD;
            end
            ST_NEGD: if (dly_done) begin
                st_next = ST_NEXTD; // R6
            end
            ST_NEXTD: if (dly_done) begin
                st_next = ST_IDLE; // R7
            end
            default: st_next = ST_IDLE;
        endcase
        if (!is_master) begin
            st_next = ST_IDLE;
        end
    end

    assign ssl_act_next = (st_next == ST_CLKD) || (st_next == ST_XFER) || (st_next == ST_NEGD);
    assign m_start      = (st_reg != ST_XFER) && (st_next == ST_XFER);
    assign adv          = ((st_reg == ST_XFER) && (st_next == ST_CLKD)) ||
                          ((st_reg == ST_NEXTD) && (st_next == ST_IDLE) && is_master);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg      <= ST_IDLE;
            dly_cnt_reg <= 4'h0;
            hcnt_reg    <= 6'h0;
            ssl_act_reg <= 1'b0;
            cmd_ptr_reg <= SEQ_RST;
        end else begin
            st_reg      <= st_next;
            ssl_act_reg <= ssl_act_next;
            dly_cnt_reg <= (st_next != st_reg) ? 4'h0 : dly_cnt_reg + {3'h0, half};
            hcnt_reg    <= (st_reg != ST_XFER) ? 6'h0 : hcnt_reg + {5'h0, half};
            if (!is_master) begin
                cmd_ptr_reg <= SEQ_RST;
            end else if (adv) begin
                cmd_ptr_reg <= (cmd_ptr_reg == i_seq_last) ? SEQ_RST : cmd_ptr_reg + 3'h1; // R9
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sck_reg <= 1'b0;
        end else if (st_reg != ST_XFER) begin
            sck_reg <= cpol; // R10
        end else if (half) begin
            sck_reg <= ~sck_reg;
        end
    end

    // ****************************************
    // Shared shift datapath
    // ****************************************
    logic        sck_prev_reg;
    logic        sl_sel_prev_reg;
    logic        s_reload_reg;
    logic        lead;
    logic        trail;
    logic        smp;
    logic        shf;
    logic        start;
    logic        din;
    logic [31:0] tx_hold_reg;
    logic [31:0] tx_sh_reg;
    logic [31:0] tx_sh_next;
    logic [31:0] rx_sh_reg;
    logic [31:0] rx_word;
    logic [4:0]  bit_cnt_reg;
    logic        first_reg;
    logic        frame_done;
    logic        out_bit;

    assign lead  = ((st_reg == ST_XFER) && half && !hcnt_reg[0]) ||
                   (sl_sel && (i_sck != sck_prev_reg) && (i_sck != cpol));
    assign trail = ((st_reg == ST_XFER) && half && hcnt_reg[0]) ||
                   (sl_sel && (i_sck != sck_prev_reg) && (i_sck == cpol));
    assign smp   = cpha ? trail : lead;
    assign shf   = cpha ? lead : trail;
    assign start = m_start || (sl_sel && (!sl_sel_prev_reg || s_reload_reg));
    assign din   = is_slave ? i_mosi : i_miso;
    assign rx_word    = f_rx_ins(rx_sh_reg, din, lsb, len);
    assign frame_done = smp && (bit_cnt_reg == len);

    always_comb begin
        tx_sh_next = tx_sh_reg;
        if (start) begin
            tx_sh_next = tx_full_reg ? tx_hold_reg : 32'h0;
        end else if (shf && !(cpha && first_reg)) begin
            tx_sh_next = f_tx_sh(tx_sh_reg, lsb);
        end
    end
    assign out_bit = lsb ? tx_sh_next[0] : tx_sh_next[len];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_sh_reg       <= 32'h0;
            rx_sh_reg       <= 32'h0;
            bit_cnt_reg     <= 5'h0;
            first_reg       <= 1'b0;
            sck_prev_reg    <= 1'b0;
            sl_sel_prev_reg <= 1'b0;
            s_reload_reg    <= 1'b0;
        end else begin
            tx_sh_reg       <= tx_sh_next;
            sck_prev_reg    <= i_sck;
            sl_sel_prev_reg <= sl_sel;
            s_reload_reg    <= frame_done && sl_sel;
            if (start) begin
                rx_sh_reg   <= 32'h0;
                bit_cnt_reg <= 5'h0;
                first_reg   <= 1'b1;
            end else begin
                if (smp) begin
                    rx_sh_reg   <= rx_word;
                    bit_cnt_reg <= bit_cnt_reg + 5'h1;
                end
                if (shf) begin
                    first_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Buffers, flags and events
    // ****************************************
    logic tx_load;
    logic rx_store;
    logic modf_set;
    logic udr_set;
    logic ovr_set;
    logic par_set;
    logic udr_reg;
    logic ovr_reg;
    logic par_reg;
    logic idle_now;
    logic idle_reg;

    assign tx_load  = start && tx_full_reg;
    assign rx_store = frame_done && (!rx_full_reg || i_rx_rd);
    assign modf_set = i_enable && (i_mode == MODE_MULTI) && ssl0_act; // R3
    assign udr_set  = start && is_slave && !tx_full_reg;
    assign ovr_set  = frame_done && rx_full_reg && !i_rx_rd;
    assign par_set  = frame_done && i_par_en && ^rx_word;
    assign idle_now = (st_reg == ST_IDLE) && !tx_full_reg && !sl_sel;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_full_reg <= 1'b0;
            tx_hold_reg <= 32'h0;
            rx_full_reg <= 1'b0;
            o_rx_data   <= 32'h0;
        end else begin
            if (i_tx_wr && !tx_full_reg) begin
                tx_full_reg <= 1'b1; // R11
                tx_hold_reg <= i_tx_data;
            end else if (tx_load) begin
                tx_full_reg <= 1'b0; // R14
            end
            if (rx_store) begin
                rx_full_reg <= 1'b1; // R13
                o_rx_data   <= rx_word;
            end else if (i_rx_rd) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            modf_reg <= 1'b0;
            udr_reg  <= 1'b0;
            ovr_reg  <= 1'b0;
            par_reg  <= 1'b0;
            idle_reg <= 1'b1;
        end else begin
            modf_reg <= (modf_reg && !i_err_clr) || modf_set;
            udr_reg  <= (udr_reg && !i_err_clr) || udr_set;
            ovr_reg  <= (ovr_reg && !i_err_clr) || ovr_set;
            par_reg  <= (par_reg && !i_err_clr) || par_set;
            idle_reg <= idle_now;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_modf_flag    <= 1'b0;
            o_udr_flag     <= 1'b0;
            o_ovr_flag     <= 1'b0;
            o_par_flag     <= 1'b0;
            o_irq_rx_full  <= 1'b0;
            o_irq_tx_empty <= 1'b0;
            o_irq_err      <= 1'b0;
            o_irq_idle     <= 1'b0;
            o_evt_rx_full  <= 1'b0;
            o_evt_tx_empty <= 1'b0;
            o_evt_err      <= 1'b0;
            o_evt_idle     <= 1'b0;
            o_evt_tx_done  <= 1'b0;
        end else begin
            o_modf_flag    <= modf_reg || udr_reg; // R21
            o_udr_flag     <= udr_reg;
            o_ovr_flag     <= ovr_reg;
            o_par_flag     <= par_reg;
            o_irq_rx_full  <= rx_full_reg; // R13
            o_irq_tx_empty <= !tx_full_reg && i_enable; // R14
            o_irq_err      <= modf_reg || udr_reg || ovr_reg || par_reg; // R15
            o_irq_idle     <= idle_reg && i_enable; // R16
            o_evt_rx_full  <= rx_store; // R17
            o_evt_tx_empty <= tx_load;
            o_evt_err      <= modf_set || udr_set || ovr_set || par_set;
            o_evt_idle     <= idle_now && !idle_reg;
            o_evt_tx_done  <= frame_done;
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sck       <= 1'b0;
            o_sck_oe_n  <= 1'b1;
            o_mosi      <= 1'b0;
            o_mosi_oe_n <= 1'b1;
            o_miso      <= 1'b0;
            o_miso_oe_n <= 1'b1;
            o_ssl       <= 4'h0;
            o_ssl_oe_n  <= SSL_IDLE_OE;
        end else begin
            o_sck       <= (st_reg != ST_XFER) ? cpol : (half ? ~sck_reg : sck_reg);
            o_sck_oe_n  <= !is_master;
            o_mosi      <= ssl_act_next ? out_bit : i_mosi_idle; // R12
            o_mosi_oe_n <= !is_master;
            o_miso      <= out_bit;
            o_miso_oe_n <= !sl_sel; // R4
            for (int k = 0; k < 4; k++) begin
                o_ssl[k] <= ~((ssl_act_next && (cur[F_SSL +: W_SSL] == 2'(k))) ^ i_ssl_pol[k]); // R8
            end
            if (!i_enable || is_slave || (i_mode == 2'h3)) begin
                o_ssl_oe_n <= SSL_IDLE_OE; // R1 R4
            end else if (i_mode == MODE_MULTI) begin
                o_ssl_oe_n <= modf_reg ? SSL_IDLE_OE : {~i_mm_ssl_used, 1'b1}; // R3
            end else begin
                o_ssl_oe_n <= 4'h0; // R2
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    chk_single_drive: assert property (i_enable && i_mode == MODE_SINGLE |=> o_ssl_oe_n == 4'h0) // R2
        else $error("single master select lines not driven");
    chk_multi_zero_in: assert property (i_enable && i_mode == MODE_MULTI |=> o_ssl_oe_n[0]) // R3
        else $error("line zero driven in multi master");
    chk_slave_free: assert property (is_slave |=> o_ssl_oe_n == 4'hf && o_sck_oe_n) // R4
        else $error("slave drives select or clock");
    chk_clk_delay: assert property ($rose(st_reg == ST_XFER) |-> $past(st_reg) == ST_CLKD && $past(ssl_act_reg, 2)) // R5
        else $error("clock started without select delay");
    chk_neg_delay: assert property (st_reg == ST_NEGD |-> ssl_act_reg && sck_reg == cpol) // R6
        else $error("select dropped during negation delay");
    chk_next_wait: assert property ($fell(ssl_act_reg) |-> !ssl_act_reg [*2]) // R7
        else $error("next access wait too short");
    chk_seq_wrap: assert property (adv && is_master && cmd_ptr_reg == i_seq_last |=> cmd_ptr_reg == 3'h0) // R9
        else $error("command loop did not wrap");
    chk_idle_mosi: assert property ($past(i_arst_n) && st_reg == ST_IDLE && // R12
        $past(st_reg) == ST_IDLE && $past(is_master) |-> o_mosi == $past(i_mosi_idle))
        else $error("data line not at idle level");
    chk_rx_full: assert property (frame_done && !rx_full_reg |=> o_evt_rx_full ##1 o_irq_rx_full) // R13
        else $error("receive full not raised");
    chk_ovr_err: assert property (ovr_set |=> ##1 o_irq_err && o_ovr_flag) // R15
        else $error("overrun not reported");
    chk_rx_hold: assert property (st_reg == ST_CLKD && rx_full_reg |=> st_reg != ST_XFER) // R18
        else $error("clock ran with receive buffer full");
    chk_udr_modf: assert property (udr_set |=> ##1 o_modf_flag && o_udr_flag) // R21
        else $error("underrun not shown in mode fault flag");

    cov_master_frame: cover property (st_reg == ST_XFER ##[1:300] st_reg == ST_NEXTD);
    cov_burst: cover property (st_reg == ST_XFER ##1 st_reg == ST_CLKD);
    cov_slave_frame: cover property (sl_sel && frame_done);
    cov_wrap: cover property (adv && cmd_ptr_reg == 3'h7);
endmodule
`default_nettype wire

// >>> ssc_pkg.sv
// Shared constants and types for the select-line command sequencer
`default_nettype none
package ssc_pkg;

    // ****************************************
    // Command word layout
    // ****************************************
    localparam int CMD_W     = 32;
    localparam int F_SSL     = 30;
    localparam int W_SSL     = 2;
    localparam int F_RATIO   = 18;
    localparam int W_RATIO   = 12;
    localparam int F_CPOL    = 17;
    localparam int F_CPHA    = 16;
    localparam int F_LEN     = 11;
    localparam int W_LEN     = 5;
    localparam int F_LSB     = 10;
    localparam int F_BURST   = 9;
    localparam int F_CLKD    = 6;
    localparam int F_NEGD    = 3;
    localparam int F_NXTD    = 0;
    localparam int W_DLY     = 3;

    // ****************************************
    // Reset values and limits
    // ****************************************
    // Ratio 2, 8 bit frame, MSB first, mode 0, delays 1 cycle
    localparam logic [CMD_W-1:0] CMD_RST     = 32'h0004_3800;
    localparam logic [2:0]       SEQ_RST     = 3'h0;
    localparam logic [3:0]       SSL_IDLE_OE = 4'hf;
    localparam int               SLV_MIN_DIV = 4;

    // ****************************************
    // Modes and master states
    // ****************************************
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_MULTI  = 2'h1,
        MODE_SLAVE  = 2'h2
    } ssc_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_CLKD  = 3'h1,
        ST_XFER  = 3'h3,
        ST_NEGD  = 3'h2,
        ST_NEXTD = 3'h6
    } ssc_mst_e;

endpackage
`default_nettype wire

// >>> ssc_slave_model.sv
// Behavioural SPI slave, mode 0, answering a fixed pattern
`default_nettype none
module ssc_slave_model #(
    parameter logic [7:0] PAT = 8'ha5
) (
    input  wire logic i_sck,
    input  wire logic i_sel_n,
    output logic      o_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Shifter
    // ****
    logic [7:0] sh = 8'h00;
    always @(negedge i_sel_n) sh = PAT;
    always @(negedge i_sck) if (!i_sel_n) sh = {sh[6:0], ~sh[7]};
    // Released line shows the inverse
    always @(*) o_miso = i_sel_n ? ~sh[7] : sh[7];
endmodule
`default_nettype wire

// >>> test_spi_select_command_sequencer.sv
// Self-checking bench for the select-line command sequencer
`default_nettype none
module test_spi_select_command_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    import ssc_pkg::*;
    // ****
    // Signals and tasks
    // ****
    logic i_clk, i_arst_n, i_enable, i_mosi_idle, i_par_en, i_cmd_we, i_tx_wr, i_rx_rd;
    logic i_err_clr, i_sck, i_mosi, i_miso, i_ssl0;
    logic [1:0] i_mode;
    logic [2:0] i_mm_ssl_used, i_seq_last, i_cmd_addr;
    logic [3:0] i_ssl_pol, o_ssl, o_ssl_oe_n;
    logic [31:0] i_cmd_word, i_tx_data, o_rx_data, rxd;
    logic o_modf_flag, o_udr_flag, o_ovr_flag, o_par_flag, o_irq_rx_full, o_irq_tx_empty;
    logic o_irq_err, o_irq_idle, o_evt_rx_full, o_evt_tx_empty, o_evt_err, o_evt_idle;
    logic o_evt_tx_done, o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n;
    int failures, samples_checked, cyc, ln, d1, d2, e1, e2, t1, t2;
    ssc_core DUT (.*);
    ssc_slave_model PARTNER (.i_sck(o_sck), .i_sel_n(o_ssl[0]), .o_miso(i_miso));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Counts: checked=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures++;
            close_out();
        end
    end
    task automatic wcmd(input logic [2:0] a, input logic [31:0] w);
        @(posedge i_clk) begin i_cmd_we <= 1'b1; i_cmd_addr <= a; i_cmd_word <= w; end
        @(posedge i_clk) i_cmd_we <= 1'b0;
    endtask
    task automatic go(output int ln, dly, edg, tl);
        logic s0;
        ln = -1; dly = 0; edg = 1; tl = 0;
        @(posedge i_clk) i_tx_wr <= 1'b1;
        @(posedge i_clk) i_tx_wr <= 1'b0;
        for (int n = 0; n < 400 && ln < 0; n++) begin
            @(negedge i_clk);
            for (int k = 0; k < 4; k++) if (o_ssl[k] !== ~i_ssl_pol[k]) ln = k;
            if (ln < 0) chk(o_mosi, i_mosi_idle);
        end
        if (ln < 0) ln = 0;
        s0 = o_sck;
        while (o_sck === s0 && dly < 400) begin @(negedge i_clk); dly++; end
        s0 = o_sck;
        while (o_ssl[ln] !== ~i_ssl_pol[ln] && tl < 400) begin
            @(negedge i_clk);
            tl++;
            if (o_sck !== s0) begin edg++; s0 = o_sck; tl = 0; end
        end
        chk(o_irq_rx_full, 1);
        rxd = o_rx_data;
        @(posedge i_clk) i_rx_rd <= 1'b1;
        @(posedge i_clk) i_rx_rd <= 1'b0;
        for (int n = 0; n < 400 && o_irq_idle !== 1'b1; n++) @(negedge i_clk);
        chk(o_irq_idle, 1);
        chk(o_mosi, i_mosi_idle);
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        {i_par_en, i_cmd_we, i_tx_wr, i_rx_rd, i_err_clr, i_sck, i_mosi} = '0;
        {i_enable, i_mosi_idle, i_ssl0} = 3'h7;
        {i_mode, i_mm_ssl_used, i_seq_last, i_cmd_addr, i_ssl_pol} = '0;
        {i_cmd_word, i_tx_data} = {32'h0, 32'h0000_00c3};
        failures = 0; samples_checked = 0; i_arst_n = 1'b0;
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(negedge i_clk);
        chk(o_ssl, 4'hf);
        chk(o_ssl_oe_n, 4'h0);
        chk(o_irq_tx_empty, 1);
        wcmd(3'h0, CMD_RST);
        go(ln, d1, e1, t1);
        chk(e1, 16);
        chk(rxd, 32'h0000_00a5);
        wcmd(3'h0, CMD_RST | (32'h8 << F_LEN) | (32'h3 << F_CLKD) | (32'h3 << F_NEGD));
        go(ln, d2, e2, t2);
        chk(e2, 32);
        chk(rxd, 32'h0000_a55a);
        chk(d2 - d1, 6);
        chk(t2 - t1, 6);
        $display("test master timing done");
        @(posedge i_clk) begin i_ssl_pol <= 4'h6; i_seq_last <= 3'h1; end
        wcmd(3'h0, CMD_RST | (32'h1 << F_SSL));
        wcmd(3'h1, CMD_RST | (32'h2 << F_SSL));
        for (int i = 0; i < 3; i++) begin
            go(ln, d1, e1, t1);
            chk(ln, (i % 2) + 1);
        end
        chk(o_ssl, 4'h9);
        $display("test command loop done");
        @(posedge i_clk) begin i_mode <= 2'h2; i_ssl_pol <= 4'h0; end
        @(posedge i_clk) i_ssl0 <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_ssl_oe_n, 4'hf);
        chk(o_miso_oe_n, 0);
        chk(o_miso, 0);
        repeat (16) begin repeat (2) @(posedge i_clk); i_sck <= ~i_sck; end
        @(posedge i_clk) i_ssl0 <= 1'b1;
        for (int n = 0; n < 100 && o_irq_err !== 1'b1; n++) @(negedge i_clk);
        chk({o_irq_err, o_modf_flag, o_udr_flag}, 3'h7);
        @(posedge i_clk) i_err_clr <= 1'b1;
        @(posedge i_clk) i_err_clr <= 1'b0;
        repeat (2) @(negedge i_clk);
        chk({o_irq_err, o_modf_flag}, 2'h0);
        $display("test slave underrun done");
        @(posedge i_clk) begin i_mode <= 2'h1; i_mm_ssl_used <= 3'h5; end
        repeat (3) @(negedge i_clk);
        chk(o_ssl_oe_n, 4'h5);
        @(posedge i_clk) i_ssl0 <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk({o_modf_flag, o_irq_err, o_sck_oe_n, o_ssl_oe_n}, 7'h7f);
        @(posedge i_clk) i_ssl0 <= 1'b1;
        @(posedge i_clk) i_err_clr <= 1'b1;
        @(posedge i_clk) i_err_clr <= 1'b0;
        repeat (2) @(negedge i_clk);
        chk({o_modf_flag, o_ssl_oe_n}, 5'h05);
        $display("test multi master done");
        close_out();
    end
endmodule
`default_nettype wire
